/* File: inc/rbm_pkg.sv */
// Package of the retentive bit memory: widths, counts, reset values and states.
// Assumes a single 125 MHz clock domain and no software-visible registers.
`default_nettype none

package rbm_pkg;

   // ----------------------------------------------------------------
   // Widths and configured counts
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] DATA_CNT_MIN = 4'h1;
   localparam logic [CNT_W-1:0] DATA_CNT_MAX = 4'h8;
   // Inputs: data, strobe and optional clear; outputs: data and status
   localparam int IN_CNT_MIN = 3;
   localparam int IN_CNT_MAX = 10;
   localparam int OUT_CNT_MIN = 2;
   localparam int OUT_CNT_MAX = 9;
   // Upper bound on instances in one project, kept by the project tooling
   localparam int INST_MAX = 2;

   // ----------------------------------------------------------------
   // Values after reset and erase
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ERASED = 8'h00;
   localparam logic STATUS_RST = 1'b0;
   localparam logic STORE_PREV_RST = 1'b0;
   localparam logic REV_NEW_RST = 1'b0;
   localparam logic SYNC_RST = 1'b0;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int SYNC_STAGES = 2;
   localparam int RESTORE_CYCLES = 1;

   // ----------------------------------------------------------------
   // Store sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RBM_RESTORE,
      RBM_WAIT_LOW,
      RBM_ARMED,
      RBM_HELD
   } rbm_state_e;

endpackage

`default_nettype wire

/* File: rtl/rbm_sync2.sv */
// Two-flop synchroniser for level pins of the retentive bit memory.
// Assumes the pin is a slow level; the first stage feeds only the second.
`timescale 1ns/10ps
`default_nettype none

module rbm_sync2
   import rbm_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic [W-1:0] pin_i, // Asynchronous level
   output logic [W-1:0] lvl_o // Synchronised level
);

   logic [W-1:0] meta;

   // ----------------------------------------------------------------
   // Two stages
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= {W{SYNC_RST}};
         lvl_o <= {W{SYNC_RST}};
      end else begin
         meta <= pin_i;
         lvl_o <= meta;
      end
   end

endmodule

`default_nettype wire

/* File: rtl/rbm_qual.sv */
// Qualifier that turns a pre-processed level and its test-pulse error into
// the evaluated level. Assumes both inputs come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module rbm_qual
   import rbm_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic [W-1:0] lvl_i, // Pre-processed level
   input wire logic [W-1:0] tpe_i, // Test pulse error per bit
   output logic [W-1:0] lvl_o // Evaluated level
);

   // ----------------------------------------------------------------
   // A high level with a test pulse error counts as low
   // ----------------------------------------------------------------
   assign lvl_o = lvl_i & ~tpe_i;

endmodule

`default_nettype wire

/* File: rtl/rbm_core.sv */
// Retentive bit memory top: one clock, no register bus.
// Assumes reset marks power-up or stop-to-run, and the retentive image
// lives in flops that reset does not touch.
`timescale 1ns/10ps
`default_nettype none

module rbm_core
   import rbm_pkg::*;
(
   input wire logic clk_i, // 125 MHz logic cycle clock
   input wire logic rst_n_i, // Power-up or stop-to-run, active low
   input wire logic run_i, // Controller in operating state
   input wire logic rev_new_i, // Newer revision behaviour strap
   input wire logic [CNT_W-1:0] data_cnt_i, // Data inputs in use, 1 to 8
   input wire logic clear_en_i, // Clear input configured
   input wire logic [DATA_W-1:0] data_i, // Data inputs
   input wire logic [DATA_W-1:0] data_tpe_i, // Data test pulse errors
   input wire logic store_i, // Store strobe
   input wire logic store_tpe_i, // Store strobe test pulse error
   input wire logic clear_i, // Clear input
   input wire logic clear_tpe_i, // Clear input test pulse error
   input wire logic power_fail_i, // Supply failing, async pin
   input wire logic card_removed_i, // Card pulled under power, async pin
   input wire logic project_new_i, // New valid project detected
   input wire logic project_verify_i, // Verify or falsify, not a new project
   input wire logic project_download_i, // Project downloaded
   output logic [DATA_W-1:0] data_o, // Stored data bits
   output logic status_o, // High while operating
   output logic commit_o, // Pulse: retentive image written
   output logic erase_o // High the cycle after each cycle that erases the retentive image
);

   // ----------------------------------------------------------------
   // Input qualification and synchronisation
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] data_lv;
   logic [1:0] ctl_lv;
   logic [1:0] pin_lv;
   logic store_lv;
   logic clear_lv;
   logic pf_lv;
   logic card_lv;

   rbm_qual #(.W(DATA_W)) u_data_qual (
      .lvl_i(data_i),
      .tpe_i(data_tpe_i),
      .lvl_o(data_lv)
   );

   rbm_qual #(.W(2)) u_ctl_qual (
      .lvl_i({clear_i, store_i}),
      .tpe_i({clear_tpe_i, store_tpe_i}),
      .lvl_o(ctl_lv)
   );

   rbm_sync2 #(.W(2)) u_pin_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i({card_removed_i, power_fail_i}),
      .lvl_o(pin_lv)
   );

   assign store_lv = ctl_lv[0];
   assign clear_lv = ctl_lv[1] & clear_en_i;
   assign pf_lv = pin_lv[0];
   assign card_lv = pin_lv[1];

   // ----------------------------------------------------------------
   // Configured width
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] cnt_eff;
   logic [DATA_W:0] mask_full;
   logic [DATA_W-1:0] data_mask;
   logic [DATA_W-1:0] data_masked;

   assign cnt_eff = (data_cnt_i < DATA_CNT_MIN) ? DATA_CNT_MIN :
                    (data_cnt_i > DATA_CNT_MAX) ? DATA_CNT_MAX : data_cnt_i;
   assign mask_full = (9'h001 << cnt_eff) - 9'h001;
   assign data_mask = mask_full[DATA_W-1:0];
   assign data_masked = data_lv & data_mask;

   // ----------------------------------------------------------------
   // Sequencer state and edge detection
   // ----------------------------------------------------------------
   rbm_state_e state;
   rbm_state_e next_state;
   logic store_prev;
   logic pf_prev;
   logic rev_new;
   logic [DATA_W-1:0] nv_image;

   logic store_rise;
   logic pf_rise;
   logic in_restore;
   logic armed;
   logic edge_held;
   logic capture_w;
   logic clear_w;
   logic proj_erase_w;
   logic erase_w;
   logic pf_commit_w;
   logic write_w;

   assign store_rise = store_lv & ~store_prev;
   assign pf_rise = pf_lv & ~pf_prev;
   assign in_restore = (state == RBM_RESTORE);
   assign armed = (state == RBM_ARMED);
   assign edge_held = (state == RBM_HELD);

   assign capture_w = armed & store_rise & ~clear_lv;
   assign clear_w = (armed & store_rise | edge_held & store_lv) & clear_lv;
   assign proj_erase_w = rev_new ? (project_new_i & ~project_verify_i)
                                 : (project_download_i | card_lv);
   assign erase_w = ~in_restore & (clear_w | proj_erase_w);
   assign pf_commit_w = edge_held & store_lv & pf_rise & ~clear_lv;
   assign write_w = ~erase_w & (capture_w | pf_commit_w);

   always_comb begin
      next_state = state;
      case (state)
         RBM_RESTORE: begin
            next_state = RBM_WAIT_LOW;
         end
         RBM_WAIT_LOW: begin
            if (!store_lv) begin
               next_state = RBM_ARMED;
            end
         end
         RBM_ARMED: begin
            if (store_rise) begin
               next_state = RBM_HELD;
            end
         end
         RBM_HELD: begin
            if (!store_lv) begin
               next_state = RBM_ARMED;
            end
         end
         default: begin
            next_state = RBM_RESTORE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= RBM_RESTORE;
         store_prev <= STORE_PREV_RST;
         pf_prev <= SYNC_RST;
      end else begin
         state <= next_state;
         store_prev <= store_lv;
         pf_prev <= pf_lv;
      end
   end

   // Revision strap caught in the restore cycle after reset release
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rev_new <= REV_NEW_RST;
      end else if (in_restore) begin
         rev_new <= rev_new_i;
      end
   end

   // ----------------------------------------------------------------
   // Retentive image: survives reset, only erase or write change it
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] next_nv;

   assign next_nv = erase_w ? DATA_ERASED : (write_w ? data_masked : nv_image);

   always_ff @(posedge clk_i) begin
      nv_image <= next_nv;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] next_data;

   assign next_data = in_restore ? nv_image : next_nv;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_o <= DATA_RST;
         status_o <= STATUS_RST;
         commit_o <= 1'b0;
         erase_o <= 1'b0;
      end else begin
         data_o <= next_data;
         status_o <= run_i;
         commit_o <= write_w;
         erase_o <= erase_w;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   restore_load_a: assert property (
      in_restore ##1 !in_restore |-> data_o === $past(nv_image))
      else $error("outputs not restored from retentive image");

   capture_out_a: assert property (
      capture_w && !proj_erase_w |=> data_o == $past(data_masked) && commit_o)
      else $error("rising strobe did not capture inputs");

   low_hold_a: assert property (
      !store_lv && !in_restore && !erase_w ##1 !store_lv && !erase_w |=> $stable(data_o))
      else $error("outputs changed while strobe low");

   fail_commit_a: assert property (
      pf_commit_w && !erase_w |=> nv_image == $past(data_masked))
      else $error("power fail did not commit inputs");

   powerup_refuse_a: assert property (
      state == RBM_WAIT_LOW |-> !write_w && !clear_w)
      else $error("capture taken before strobe went low");

   clear_both_a: assert property (
      clear_w |=> data_o == DATA_ERASED && nv_image == DATA_ERASED && erase_o)
      else $error("clear did not erase image and outputs");

   new_proj_a: assert property (
      !in_restore && rev_new && project_new_i && !project_verify_i |=> nv_image == DATA_ERASED)
      else $error("new project did not erase image");

   old_rev_a: assert property (
      !in_restore && !rev_new && project_download_i |=> nv_image == DATA_ERASED)
      else $error("download did not erase image on older revision");

   status_run_a: assert property (
      rst_n_i && run_i |=> status_o)
      else $error("status low while operating");

   tpe_zero_a: assert property (
      capture_w && !proj_erase_w && data_tpe_i[0] |=> !data_o[0])
      else $error("bit with test pulse error stored as one");

   width_mask_a: assert property (
      write_w |=> (data_o & ~$past(data_mask)) == DATA_ERASED)
      else $error("unused data bit stored");

   edge_only_a: assert property (
      capture_w |-> !store_prev ##1 edge_held)
      else $error("capture without strobe edge");

   out_image_a: assert property (
      !in_restore ##1 !in_restore |-> data_o === $past(next_nv))
      else $error("outputs differ from retentive image");

   capture_c: cover property (capture_w ##[1:20] !store_lv);
   clear_c: cover property (clear_w);
   fail_c: cover property (pf_commit_w);
   restore_high_c: cover property (in_restore && store_lv ##1 state == RBM_WAIT_LOW);

endmodule

`default_nettype wire

/* File: dv/rbm_partner.sv */
// Model of the controller logic program that drives the store strobe,
// clear input and data inputs. Assumes one clock shared with the block.
`timescale 1ns/10ps
`default_nettype none

module rbm_partner (
   input wire logic clk_i, // Logic cycle clock
   output logic store_o, // Store strobe
   output logic clear_o, // Clear input
   output logic [7:0] data_o // Data inputs
);
   initial begin
      store_o <= 1'b0;
      clear_o <= 1'b0;
      data_o <= 8'h00;
   end

   // ----------------------------------------------------------------
   // Drive tasks, each change lands on a rising edge
   // ----------------------------------------------------------------
   task automatic set_store(input logic v);
      @(posedge clk_i);
      store_o <= v;
   endtask

   task automatic set_clear(input logic v);
      @(posedge clk_i);
      clear_o <= v;
   endtask

   task automatic set_data(input logic [7:0] d);
      @(posedge clk_i);
      data_o <= d;
   endtask

   // Strobe drops before the data moves, then rises again
   task automatic rise(input logic [7:0] d);
      set_store(1'b0);
      set_data(d);
      set_store(1'b1);
   endtask
endmodule

`default_nettype wire

/* File: dv/retentive_bit_memory_tb.sv */
// Self-checking bench of the retentive bit memory core.
// Assumes the partner model drives strobe, clear and data inputs.
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module retentive_bit_memory_tb;
   import rbm_pkg::*;
   logic clk_i;
   logic rst_n_i;
   logic run_i, rev_new_i, clear_en_i;
   logic [CNT_W-1:0] data_cnt_i;
   logic [DATA_W-1:0] data_tpe_i;
   logic store_tpe_i, clear_tpe_i, power_fail_i;
   logic card_removed_i, project_new_i, project_verify_i;
   logic project_download_i;
   wire logic store, clear;
   wire logic [DATA_W-1:0] data;
   logic [DATA_W-1:0] data_o;
   logic status_o, commit_o, erase_o;
   int error_cnt = 0, samples_checked = 0, commits = 0, erases = 0;

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   rbm_partner rbm_partner_i (.clk_i(clk_i), .store_o(store), .clear_o(clear),
      .data_o(data));

   rbm_core rbm_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run_i),
      .rev_new_i(rev_new_i), .data_cnt_i(data_cnt_i), .clear_en_i(clear_en_i),
      .data_i(data), .data_tpe_i(data_tpe_i), .store_i(store), .store_tpe_i(store_tpe_i),
      .clear_i(clear), .clear_tpe_i(clear_tpe_i), .power_fail_i(power_fail_i),
      .card_removed_i(card_removed_i), .project_new_i(project_new_i),
      .project_verify_i(project_verify_i), .project_download_i(project_download_i),
      .data_o(data_o), .status_o(status_o), .commit_o(commit_o), .erase_o(erase_o));

   always @(posedge clk_i) begin
      if (commit_o === 1'b1) commits++;
      if (erase_o === 1'b1) erases++;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Waits for a commit (er=0) or an erase (er=1) pulse
   task automatic wait_evt(input bit er);
      int c0;
      int k;
      c0 = er ? erases : commits;
      for (k = 0; k < 20 && (er ? erases : commits) == c0; k++) cyc(1);
      if ((er ? erases : commits) == c0) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask

   task automatic do_reset;
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      power_fail_i <= 1'b0;
      cyc(2);
      `CHK(data_o, DATA_RST)
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      cyc(3);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_init_status;
      project_download_i <= 1'b1;
      @(posedge clk_i);
      project_download_i <= 1'b0;
      wait_evt(1);
      `CHK(data_o, DATA_ERASED)
      run_i <= 1'b1;
      cyc(2);
      `CHK(status_o, 1'b1)
      @(posedge clk_i);
      run_i <= 1'b0;
      cyc(2);
      `CHK(status_o, 1'b0)
      run_i <= 1'b1;
   endtask

   task automatic t_capture;
      int c;
      rbm_partner_i.rise(8'hA5);
      wait_evt(0);
      `CHK(data_o, 8'hA5)
      c = commits;
      rbm_partner_i.set_data(8'h3C);
      cyc(4);
      `CHK(commits, c)
      rbm_partner_i.set_store(1'b0);
      rbm_partner_i.set_data(8'h11);
      cyc(4);
      `CHK(data_o, 8'hA5)
      data_cnt_i <= 4'h4;
      rbm_partner_i.rise(8'hFF);
      wait_evt(0);
      `CHK(data_o, 8'h0F)
      data_cnt_i <= 4'h0;
      rbm_partner_i.rise(8'hFF);
      wait_evt(0);
      `CHK(data_o, 8'h01)
      data_cnt_i <= 4'h8;
   endtask

   task automatic t_tpe;
      int c;
      data_tpe_i <= 8'h81;
      rbm_partner_i.rise(8'hFF);
      wait_evt(0);
      `CHK(data_o, 8'h7E)
      data_tpe_i <= 8'h00;
      store_tpe_i <= 1'b1;
      c = commits;
      rbm_partner_i.rise(8'h55);
      cyc(4);
      `CHK(commits, c)
      @(posedge clk_i);
      store_tpe_i <= 1'b0;
      wait_evt(0);
      `CHK(data_o, 8'h55)
   endtask

   task automatic t_clear;
      int e;
      e = erases;
      clear_tpe_i <= 1'b1;
      rbm_partner_i.set_clear(1'b1);
      cyc(4);
      `CHK(erases, e)
      @(posedge clk_i);
      clear_tpe_i <= 1'b0;
      wait_evt(1);
      `CHK(data_o, DATA_ERASED)
      rbm_partner_i.set_clear(1'b0);
      rbm_partner_i.set_store(1'b0);
      cyc(1);
      e = erases;
      rbm_partner_i.set_clear(1'b1);
      cyc(4);
      `CHK(erases, e)
      // Clear not configured: a strobe edge captures despite a high clear
      clear_en_i <= 1'b0;
      rbm_partner_i.rise(8'h24);
      wait_evt(0);
      `CHK(data_o, 8'h24)
      clear_en_i <= 1'b1;
      wait_evt(1);
      `CHK(data_o, DATA_ERASED)
      rbm_partner_i.set_clear(1'b0);
   endtask

   task automatic t_power;
      int c;
      rbm_partner_i.rise(8'hC3);
      wait_evt(0);
      rbm_partner_i.set_data(8'h5A);
      @(posedge clk_i);
      power_fail_i <= 1'b1;
      wait_evt(0);
      `CHK(data_o, 8'h5A)
      do_reset();
      `CHK(data_o, 8'h5A)
      c = commits;
      rbm_partner_i.set_data(8'h77);
      cyc(4);
      `CHK(commits, c)
      rbm_partner_i.rise(8'h77);
      wait_evt(0);
      `CHK(data_o, 8'h77)
   endtask

   task automatic t_project;
      int e;
      rev_new_i <= 1'b1;
      do_reset();
      e = erases;
      project_verify_i <= 1'b1;
      project_new_i <= 1'b1;
      @(posedge clk_i);
      project_new_i <= 1'b0;
      cyc(4);
      `CHK(erases, e)
      `CHK(data_o, 8'h77)
      project_verify_i <= 1'b0;
      project_new_i <= 1'b1;
      @(posedge clk_i);
      project_new_i <= 1'b0;
      wait_evt(1);
      `CHK(data_o, DATA_ERASED)
      rev_new_i <= 1'b0;
      do_reset();
      rbm_partner_i.rise(8'h99);
      wait_evt(0);
      card_removed_i <= 1'b1;
      wait_evt(1);
      `CHK(data_o, DATA_ERASED)
      card_removed_i <= 1'b0;
      cyc(4);
   endtask

   initial begin
      rst_n_i <= 1'b0;
      run_i <= 1'b0;
      rev_new_i <= 1'b0;
      clear_en_i <= 1'b1;
      data_cnt_i <= 4'h8;
      data_tpe_i <= 8'h00;
      store_tpe_i <= 1'b0;
      clear_tpe_i <= 1'b0;
      power_fail_i <= 1'b0;
      card_removed_i <= 1'b0;
      project_new_i <= 1'b0;
      project_verify_i <= 1'b0;
      project_download_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      cyc(3);
      t_init_status();
      t_capture();
      t_tpe();
      t_clear();
      t_power();
      t_project();
      tally_and_finish();
   end
endmodule

`default_nettype wire
